// ### rtl/serial_tx.sv
// Local design decisions: the address-and-strobe port and the placing of the registers.
module serial_tx
	import sertx_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       SRST,
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	output logic            TX_OUT,
	output logic            TX_OE,
	output logic            IRQ
);
	logic [7:0] ctrl_ff, baud_ff, fine_ff, rdata_ff;
	logic [8:0] tx_holding_buffer_ff, shift_ff;
	logic       hold_full_ff, tx_buffer_empty_ff, tx_done_flag_ff, armed_ff;
	logic       out_ff, oe_ff, irq_ff, brk_tail_ff, idle_pend_ff;
	logic [3:0] bit_cnt_ff, os_cnt_ff;
	logic [3:0] coarse_cnt_ff;
	logic [6:0] range_cnt_ff;
	logic [7:0] fine_cnt_ff;
	txst_e      st_ff;

	wire word9     = ctrl_ff[CTRL_WORD9_POS];
	wire tx_enable = ctrl_ff[CTRL_TXEN_POS];
	wire send_break = ctrl_ff[CTRL_BRK_POS];
	wire wr_data   = WR && ADDR == ADDR_DATA;
	wire wr_ctrl   = WR && ADDR == ADDR_CTRL;
	wire rd_stat   = RD && ADDR == ADDR_STATUS;
	wire [3:0] frame_bits = word9 ? BITS_WORD9 : BITS_WORD8;
	wire busy      = st_ff != TX_IDLE;
	wire ten_rise  = wr_ctrl && WDATA[CTRL_TXEN_POS] && !tx_enable;
	wire ten_fall  = wr_ctrl && !WDATA[CTRL_TXEN_POS] && tx_enable;
	wire ten_toggle = wr_ctrl && (WDATA[CTRL_TXEN_POS] != tx_enable);

	function automatic logic [3:0] coarse_top(input logic [1:0] sel);
		unique case (sel)
			2'h0: coarse_top = 4'h0;
			2'h1: coarse_top = 4'h2;
			2'h2: coarse_top = 4'h3;
			default: coarse_top = 4'hc;
		endcase
	endfunction

	// baud chain: 16x oversample, coarse, range, fine; ticks once per bit
	wire [6:0] range_top = 7'((8'h1 << baud_ff[BAUD_RANGE_POS +: 3]) - 8'h1);
	wire [1:0] coarse_sel = baud_ff[BAUD_COARSE_POS +: 2];
	wire c_tick = coarse_cnt_ff == coarse_top(coarse_sel);
	wire r_tick = c_tick && range_cnt_ff == range_top;
	wire f_tick = r_tick && (fine_ff == 8'h0 || fine_cnt_ff == fine_ff - 8'h1);
	wire bit_tick = f_tick && os_cnt_ff == OVERSAMPLE;

	always_ff @(posedge CLK) begin
		if (SRST || !tx_enable || st_ff == TX_IDLE && !idle_pend_ff) begin
			coarse_cnt_ff <= 4'h0;
			range_cnt_ff  <= 7'h0;
			fine_cnt_ff   <= 8'h0;
			os_cnt_ff     <= 4'h0;
		end else begin
			coarse_cnt_ff <= c_tick ? 4'h0 : coarse_cnt_ff + 4'h1;
			if (c_tick)
				range_cnt_ff <= r_tick ? 7'h0 : range_cnt_ff + 7'h1;
			if (r_tick)
				fine_cnt_ff <= f_tick ? 8'h0 : fine_cnt_ff + 8'h1;
			if (f_tick)
				os_cnt_ff <= os_cnt_ff + 4'h1;
		end
	end

	// frame word: start(0), data lsb first, stop(1)
	function automatic logic [10:0] build(input logic [8:0] d, input logic w9);
		build = w9 ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
	endfunction
	logic [10:0] frame_ff;
	wire last_bit = bit_cnt_ff == frame_bits - 4'h1;
	wire frame_end = bit_tick && last_bit;
	wire [8:0] load_word = word9 ? {ctrl_ff[CTRL_NINTH_POS], WDATA} : {1'b0, WDATA};
	wire next_avail = hold_full_ff || send_break;
	wire idle_write = wr_data && !busy && !hold_full_ff && tx_enable && !idle_pend_ff;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			st_ff        <= TX_IDLE;
			bit_cnt_ff   <= 4'h0;
			frame_ff     <= 11'h7ff;
			idle_pend_ff <= 1'b0;
			brk_tail_ff  <= 1'b0;
		end else begin
			if (ten_rise)
				idle_pend_ff <= 1'b1;
			unique case (st_ff)
				TX_IDLE: begin
					bit_cnt_ff <= 4'h0;
					if (brk_tail_ff && tx_enable) begin
						st_ff <= TX_MARK;
					end else if (idle_pend_ff && tx_enable) begin
						st_ff        <= TX_IDLEFRM;
						frame_ff     <= 11'h7ff;
						idle_pend_ff <= 1'b0;
					end else if (tx_enable && send_break) begin
						st_ff    <= TX_DATA;
						frame_ff <= 11'h0;
					end else if (idle_write) begin
						st_ff    <= TX_DATA;
						frame_ff <= build(load_word, word9);
					end else if (tx_enable && hold_full_ff) begin
						st_ff    <= TX_DATA;
						frame_ff <= build(tx_holding_buffer_ff, word9);
					end
				end
				TX_MARK: if (bit_tick) begin
					st_ff       <= TX_IDLE;
					brk_tail_ff <= 1'b0;
				end
				default: if (bit_tick) begin
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
					frame_ff   <= {1'b1, frame_ff[10:1]};
					if (last_bit) begin
						bit_cnt_ff <= 4'h0;
						if (st_ff == TX_DATA && frame_ff[0] == 1'b0 && !send_break
							&& shift_ff == 9'h1ff)
							brk_tail_ff <= 1'b1;
						st_ff <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// marks whether the frame in flight is a break frame
	always_ff @(posedge CLK) begin
		if (SRST)
			shift_ff <= 9'h0;
		else if (st_ff == TX_IDLE && tx_enable && send_break && !idle_pend_ff && !brk_tail_ff)
			shift_ff <= 9'h1ff;
		else if (st_ff == TX_IDLE && !send_break)
			shift_ff <= 9'h0;
	end

	wire start_xfer = st_ff == TX_IDLE && tx_enable && !brk_tail_ff && !idle_pend_ff
		&& !send_break && (idle_write || hold_full_ff);

	// holding buffer, flags and clearing sequence
	always_ff @(posedge CLK) begin
		if (SRST) begin
			tx_holding_buffer_ff <= 9'h0;
			hold_full_ff         <= 1'b0;
			tx_buffer_empty_ff   <= STAT_RESET[STAT_EMPTY_POS];
			tx_done_flag_ff      <= STAT_RESET[STAT_DONE_POS];
			armed_ff             <= 1'b0;
		end else begin
			if (rd_stat)
				armed_ff <= 1'b1;
			else if (wr_data)
				armed_ff <= 1'b0;
			if (wr_data && armed_ff) begin
				tx_buffer_empty_ff <= 1'b0;
				tx_done_flag_ff    <= 1'b0;
			end
			if (wr_data && !idle_write) begin
				tx_holding_buffer_ff <= load_word;
				hold_full_ff         <= 1'b1;
			end
			if (ten_toggle)
				hold_full_ff <= 1'b0;
			if (start_xfer) begin
				tx_buffer_empty_ff <= 1'b1;
				if (!idle_write)
					hold_full_ff <= 1'b0;
			end
			if (frame_end && st_ff == TX_DATA)
				tx_done_flag_ff <= 1'b1;
		end
	end

	// control, baud and fine registers; read data one cycle later
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl_ff <= CTRL_RESET;
			baud_ff <= BAUD_RESET;
			fine_ff <= FINE_RESET;
		end else if (WR) begin
			if (ADDR == ADDR_CTRL)
				ctrl_ff <= WDATA;
			if (ADDR == ADDR_BAUD)
				baud_ff <= WDATA;
			if (ADDR == ADDR_FINE)
				fine_ff <= WDATA;
		end
	end

	wire [7:0] stat_word = {tx_buffer_empty_ff, tx_done_flag_ff, 5'h0, busy};
	wire [7:0] rd_mux = ADDR == ADDR_STATUS ? stat_word :
		ADDR == ADDR_CTRL ? ctrl_ff :
		ADDR == ADDR_BAUD ? baud_ff :
		ADDR == ADDR_FINE ? fine_ff : 8'h0;

	// line drive: low start, high stop, high idle when enabled
	wire line_en = tx_enable || ctrl_ff[CTRL_RXEN_POS];
	wire line_lvl = st_ff == TX_DATA ? frame_ff[0] : 1'b1;
	wire irq_lvl = !ctrl_ff[CTRL_GMASK_POS] &&
		(tx_buffer_empty_ff && ctrl_ff[CTRL_EIE_POS] ||
		 tx_done_flag_ff && ctrl_ff[CTRL_DIE_POS]);

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdata_ff <= 8'h0;
			out_ff   <= 1'b1;
			oe_ff    <= 1'b0;
			irq_ff   <= 1'b0;
		end else begin
			rdata_ff <= RD ? rd_mux : 8'h0;
			out_ff   <= line_lvl;
			oe_ff    <= line_en;
			irq_ff   <= irq_lvl;
		end
	end

	assign RDATA  = rdata_ff;
	assign TX_OUT = out_ff;
	assign TX_OE  = oe_ff;
	assign IRQ    = irq_ff;

	// the checks below watch internal state, so they sit beside the logic
	sequence s_stat_read;
		rd_stat;
	endsequence
	sequence s_data_write;
		wr_data && !rd_stat;
	endsequence
	sequence s_idle_start;
		idle_write && start_xfer;
	endsequence
	sequence s_break_tail;
		brk_tail_ff && st_ff == TX_IDLE && tx_enable;
	endsequence
	sequence s_frame_last;
		bit_tick && last_bit;
	endsequence

	// a write that also starts the shifter sets empty again, so it is left out
	AST_CLEAR_SEQ: assert property (@(posedge CLK) disable iff (SRST)
		s_stat_read ##1 (s_data_write and (!start_xfer)) |=> !tx_buffer_empty_ff)
		else $error("empty flag not cleared by read-write sequence");

	AST_NO_CLEAR: assert property (@(posedge CLK) disable iff (SRST)
		wr_data && !armed_ff && tx_buffer_empty_ff |=> tx_buffer_empty_ff)
		else $error("empty flag cleared without status read");

	AST_START_LOW: assert property (@(posedge CLK) disable iff (SRST)
		st_ff == TX_DATA && bit_cnt_ff == 4'h0 && !send_break && shift_ff == 9'h0 |=> !TX_OUT)
		else $error("start bit not low");

	AST_IDLE_HIGH: assert property (@(posedge CLK) disable iff (SRST)
		st_ff != TX_DATA |=> TX_OUT)
		else $error("line low outside data frame");

	AST_OE: assert property (@(posedge CLK) disable iff (SRST)
		$rose(tx_enable) |=> TX_OE)
		else $error("pin not handed to serial function");

	AST_OE_OFF: assert property (@(posedge CLK) disable iff (SRST)
		!tx_enable && !ctrl_ff[CTRL_RXEN_POS] |=> !TX_OE)
		else $error("pin kept while both directions disabled");

	AST_DONE: assert property (@(posedge CLK) disable iff (SRST)
		frame_end && st_ff == TX_DATA |=> tx_done_flag_ff)
		else $error("done flag not set after stop");

	AST_DONE_CLEAR: assert property (@(posedge CLK) disable iff (SRST)
		wr_data && armed_ff && !(frame_end && st_ff == TX_DATA) |=> !tx_done_flag_ff)
		else $error("done flag not cleared by read-write sequence");

	AST_ARM: assert property (@(posedge CLK) disable iff (SRST)
		rd_stat |=> armed_ff)
		else $error("status read did not arm the clear");

	AST_EMPTY_START: assert property (@(posedge CLK) disable iff (SRST)
		start_xfer |=> tx_buffer_empty_ff && st_ff == TX_DATA)
		else $error("transfer start did not set empty flag");

	AST_IDLE_LOAD: assert property (@(posedge CLK) disable iff (SRST)
		s_idle_start |=> st_ff == TX_DATA && frame_ff[0] == 1'b0)
		else $error("idle write did not load the shifter");

	AST_WORD9_BIT: assert property (@(posedge CLK) disable iff (SRST)
		s_idle_start ##0 word9 |=> frame_ff[9] == ctrl_ff[CTRL_NINTH_POS])
		else $error("ninth bit not taken from control");

	AST_WORD8_STOP: assert property (@(posedge CLK) disable iff (SRST)
		s_idle_start ##0 !word9 |=> frame_ff[9] == 1'b1)
		else $error("eight-bit frame has no stop bit");

	AST_STOP_HIGH: assert property (@(posedge CLK) disable iff (SRST)
		st_ff == TX_DATA && last_bit && shift_ff == 9'h0 |=> TX_OUT)
		else $error("stop bit not high");

	AST_HOLD_LOAD: assert property (@(posedge CLK) disable iff (SRST)
		wr_data && busy && !ten_toggle |=> hold_full_ff)
		else $error("busy write not held in buffer");

	AST_HOLD_DATA: assert property (@(posedge CLK) disable iff (SRST)
		wr_data && busy |=> tx_holding_buffer_ff[7:0] == $past(WDATA))
		else $error("holding buffer has wrong data");

	AST_DISCARD: assert property (@(posedge CLK) disable iff (SRST)
		ten_toggle && !wr_data |=> !hold_full_ff)
		else $error("holding buffer kept after enable toggle");

	AST_BREAK_LOW: assert property (@(posedge CLK) disable iff (SRST)
		st_ff == TX_DATA && shift_ff == 9'h1ff |=> !TX_OUT)
		else $error("break frame not all zero");

	AST_MARK_AFTER: assert property (@(posedge CLK) disable iff (SRST)
		s_break_tail |=> st_ff == TX_MARK)
		else $error("no mark bit after last break");

	AST_MARK_HIGH: assert property (@(posedge CLK) disable iff (SRST)
		st_ff == TX_MARK |=> TX_OUT)
		else $error("mark bit not high");

	AST_IDLEFRM_HIGH: assert property (@(posedge CLK) disable iff (SRST)
		st_ff == TX_IDLEFRM |=> TX_OUT)
		else $error("idle frame not all ones");

	AST_IDLEFRM_END: assert property (@(posedge CLK) disable iff (SRST)
		st_ff == TX_IDLEFRM ##0 s_frame_last |=> st_ff == TX_IDLE)
		else $error("idle frame longer than one frame");

	AST_BIT_GAP: assert property (@(posedge CLK) disable iff (SRST)
		bit_tick |=> !bit_tick)
		else $error("bit period shorter than oversample count");

	AST_IRQ_MASK: assert property (@(posedge CLK) disable iff (SRST)
		ctrl_ff[CTRL_GMASK_POS] |=> !IRQ)
		else $error("interrupt raised while masked");

	AST_IRQ_EMPTY: assert property (@(posedge CLK) disable iff (SRST)
		!ctrl_ff[CTRL_GMASK_POS] && ctrl_ff[CTRL_EIE_POS] && tx_buffer_empty_ff |=> IRQ)
		else $error("empty interrupt not raised");

	AST_IRQ_DONE: assert property (@(posedge CLK) disable iff (SRST)
		!ctrl_ff[CTRL_GMASK_POS] && ctrl_ff[CTRL_DIE_POS] && tx_done_flag_ff |=> IRQ)
		else $error("done interrupt not raised");

	AST_TOGGLE_IDLE: assert property (@(posedge CLK) disable iff (SRST)
		ten_rise |=> idle_pend_ff)
		else $error("enable toggle did not queue idle frame");

	AST_IDLE_FIRST: assert property (@(posedge CLK) disable iff (SRST)
		ten_rise |-> ##[1:3] idle_pend_ff || st_ff == TX_IDLEFRM)
		else $error("no idle frame queued on enable");

	AST_RDATA_ZERO: assert property (@(posedge CLK) disable iff (SRST)
		!RD |=> RDATA == 8'h0)
		else $error("read data shown without a read");
endmodule

// ### rtl/sertx_pkg.sv
package sertx_pkg;
	localparam logic [2:0] ADDR_DATA     = 3'h0;
	localparam logic [2:0] ADDR_STATUS   = 3'h1;
	localparam logic [2:0] ADDR_CTRL     = 3'h2;
	localparam logic [2:0] ADDR_BAUD     = 3'h3;
	localparam logic [2:0] ADDR_FINE     = 3'h4;
	// status register fields
	localparam int STAT_EMPTY_POS = 7;
	localparam int STAT_DONE_POS  = 6;
	localparam int STAT_BUSY_POS  = 0;
	// control register fields
	localparam int CTRL_WORD9_POS  = 0;
	localparam int CTRL_NINTH_POS  = 1;
	localparam int CTRL_TXEN_POS   = 2;
	localparam int CTRL_RXEN_POS   = 3;
	localparam int CTRL_BRK_POS    = 4;
	localparam int CTRL_EIE_POS    = 5;
	localparam int CTRL_DIE_POS    = 6;
	localparam int CTRL_GMASK_POS  = 7;
	// baud register fields: coarse [5:4], range [2:0]
	localparam int BAUD_COARSE_POS = 4;
	localparam int BAUD_RANGE_POS  = 0;
	localparam logic [7:0] CTRL_RESET  = 8'h80;
	localparam logic [7:0] BAUD_RESET  = 8'h00;
	localparam logic [7:0] FINE_RESET  = 8'h00;
	localparam logic [7:0] STAT_RESET  = 8'hc0;
	localparam logic [3:0] OVERSAMPLE  = 4'hf;
	localparam logic [3:0] BITS_WORD8  = 4'ha;
	localparam logic [3:0] BITS_WORD9  = 4'hb;
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_IDLEFRM, TX_MARK} txst_e;
endpackage

// ### verif/async_serial_transmitter_bench.sv
module async_serial_transmitter_bench;
	import sertx_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// baud and fine prescaler stay at reset values: 16 clocks a bit
	localparam int BIT = 16;
	logic       clk, srst, wr, rd, tx_out, tx_oe, irq, w9, stop_bit;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v;
	logic [8:0] word;
	int         frames, failures, check_count, n;

	serial_tx u_dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .TX_OUT(tx_out), .TX_OE(tx_oe), .IRQ(irq));
	sertx_line_model #(.BIT_CLKS(BIT)) u_line (.clk(clk), .line(tx_out), .word9(w9),
		.word(word), .stop_bit(stop_bit), .frames(frames));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task bus_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task wait_frame(input logic [8:0] exp, input logic stp);
		int n0;
		n0 = frames;
		for (int i = 0; i < 40 * BIT && frames == n0; i++) @(posedge clk);
		if (frames == n0) begin
			failures++;
			results();
		end
		chk("word", word, exp);
		chk("stop", 9'(stop_bit), 9'(stp));
	endtask

	// counts clocks while the line holds the given level, bounded
	task run_len(input logic lvl);
		n = 0;
		while (tx_out === lvl && n < 40 * BIT) begin
			@(posedge clk);
			n++;
		end
	endtask

	initial begin
		srst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		w9 = 1'b0;
		failures = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		bus_rd(ADDR_STATUS, v);
		chk("status", 9'(v), 9'(STAT_RESET));
		bus_rd(ADDR_CTRL, v);
		chk("ctrl", 9'(v), 9'(CTRL_RESET));
		bus_rd(3'h5, v);
		chk("unmapped", 9'(v), 9'h000);
		chk("line", 9'(tx_out), 9'h001);
		chk("oe", 9'(tx_oe), 9'h000);
		bus_wr(ADDR_CTRL, 8'h84);
		@(posedge clk);
		#1 chk("oe", 9'(tx_oe), 9'h001);
		bus_rd(ADDR_STATUS, v);
		bus_wr(ADDR_DATA, 8'ha5);
		run_len(1'b1);
		chk("idle frame", 9'(n >= 10 * BIT - 8), 9'h001);
		bus_rd(ADDR_STATUS, v);
		bus_wr(ADDR_DATA, 8'h3c);
		bus_rd(ADDR_STATUS, v);
		chk("flags", 9'(v[7:6]), 9'h000);
		wait_frame(9'h0a5, 1'b1);
		wait_frame(9'h03c, 1'b1);
		repeat (BIT) @(posedge clk);
		bus_rd(ADDR_STATUS, v);
		chk("status", 9'(v), 9'h0c0);
		bus_wr(ADDR_CTRL, 8'h24);
		repeat (2) @(posedge clk);
		#1 chk("irq", 9'(irq), 9'h001);
		// second write has no status read before it, so empty must survive
		bus_wr(ADDR_DATA, 8'h11);
		bus_wr(ADDR_DATA, 8'h22);
		@(posedge clk);
		#1 chk("irq", 9'(irq), 9'h001);
		wait_frame(9'h011, 1'b1);
		wait_frame(9'h022, 1'b1);
		bus_wr(ADDR_CTRL, 8'ha4);
		repeat (2) @(posedge clk);
		#1 chk("irq", 9'(irq), 9'h000);
		w9 = 1'b1;
		bus_wr(ADDR_CTRL, 8'h87);
		bus_rd(ADDR_STATUS, v);
		bus_wr(ADDR_DATA, 8'h01);
		wait_frame(9'h101, 1'b1);
		w9 = 1'b0;
		bus_wr(ADDR_CTRL, 8'h94);
		wait_frame(9'h000, 1'b0);
		bus_wr(ADDR_CTRL, 8'h84);
		bus_rd(ADDR_STATUS, v);
		bus_wr(ADDR_DATA, 8'h5a);
		run_len(1'b0);
		run_len(1'b1);
		chk("mark", 9'(n >= BIT - 2), 9'h001);
		wait_frame(9'h05a, 1'b1);
		results();
	end
endmodule

// ### verif/sertx_line_model.sv
module sertx_line_model #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic       clk,
	input  wire logic       line,
	input  wire logic       word9,
	output logic      [8:0] word,
	output logic            stop_bit,
	output int              frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] w;
	initial begin
		frames = 0;
		word = '0;
		stop_bit = 1'b1;
		w = '0;
		forever begin
			@(posedge clk);
			if (line === 1'b0) begin
				// recheck at mid bit so a short low pulse is not taken as a start
				repeat (BIT_CLKS / 2) @(posedge clk);
				if (line === 1'b0) begin
					w = '0;
					for (int i = 0; i < (word9 ? 9 : 8); i++) begin
						repeat (BIT_CLKS) @(posedge clk);
						w[i] = line;
					end
					repeat (BIT_CLKS) @(posedge clk);
					stop_bit = line;
					word = w;
					frames++;
				end
			end
		end
	end
endmodule
